// ---- dv/slc_host.sv ----
// Host model driving the bank's byte register port.
// Assumes clk_sys from the bench; requests change on falling edges.
`timescale 1ns/1ns
`default_nettype none
module slc_host (
	// Clock
	input  wire logic       clk_sys,
	// Register port
	output logic      [5:0] reg_addr  = 6'h00,
	output logic            reg_wr    = 1'b0,
	output logic            reg_rd    = 1'b0,
	output logic      [7:0] reg_wdata = 8'h00,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	input  wire logic       reg_miss
);
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge clk_sys);
		reg_wr    = 1'b0;
		// Data is not held past the strobe, so show its inverse
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [5:0] a, output logic [9:0] r);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge clk_sys);
		reg_rd   = 1'b0;
		r        = {reg_miss, reg_rvalid, reg_rdata};
	endtask
endmodule
`default_nettype wire

// ---- dv/slc_props.sv ----
// Checker for the slew-time loop bank, bound into slc_regs.
// Sees only the bank's ports; single clock domain on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module slc_props (
	// Clock and reset
	input wire logic                          clk_sys,
	input wire logic                          rstn,
	// Register port
	input wire logic [5:0]                    reg_addr,
	input wire logic                          reg_wr,
	input wire logic                          reg_rd,
	input wire logic [7:0]                    reg_wdata,
	input wire logic [7:0]                    reg_rdata,
	input wire logic                          reg_rvalid,
	input wire logic                          reg_miss,
	// Bridge fields
	input wire logic [3:0]                    slew_time_code_b2,
	input wire logic                          slew_loop_on_b2,
	input wire logic                          slew_err_limit_b2,
	input wire logic [1:0]                    slew_gain_code_b2,
	input wire logic [2:0]                    slew_gain_b2,
	input wire logic [slc_pkg::SLC_TIME_W-1:0] slew_time_ns_b2,
	input wire logic [3:0]                    slew_time_code_b3,
	input wire logic [3:0]                    slew_time_code_b4
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Field outputs rebuilt as a byte, so one compare covers the whole layout
	wire [7:0] cfg_b2 = {slew_time_code_b2, slew_loop_on_b2, slew_err_limit_b2, slew_gain_code_b2};
	wire [3:0] wd_t   = reg_wdata[7:4];
	sequence s_hit(a);
		reg_wr && reg_addr == a;
	endsequence
	property p_rd_ack;
		reg_rd |=> reg_rvalid;
	endproperty
	a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
	property p_rd_quiet;
		!reg_rd |=> !reg_rvalid;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("stray rvalid");
	property p_rd_b2;
		reg_rd && reg_addr == 6'h36 |=> reg_rdata == $past(cfg_b2);
	endproperty
	a_rd_b2: assert property (p_rd_b2) else $error("bridge 2 read wrong");
	property p_wr_b2;
		s_hit(6'h36) |=> cfg_b2 == $past(reg_wdata);
	endproperty
	a_wr_b2: assert property (p_wr_b2) else $error("bridge 2 write lost");
	property p_hold_b2;
		!(reg_wr && reg_addr == 6'h36) |=> $stable(cfg_b2);
	endproperty
	a_hold_b2: assert property (p_hold_b2) else $error("bridge 2 changed");
	property p_wr_b3;
		s_hit(6'h37) |=> slew_time_code_b3 == $past(wd_t);
	endproperty
	a_wr_b3: assert property (p_wr_b3) else $error("bridge 3 write lost");
	property p_wr_b4;
		s_hit(6'h38) |=> slew_time_code_b4 == $past(wd_t);
	endproperty
	a_wr_b4: assert property (p_wr_b4) else $error("bridge 4 write lost");
	property p_gain;
		1'b1 |-> slew_gain_b2 == $past(slew_gain_code_b2) + 3'h1;
	endproperty
	a_gain: assert property (p_gain) else $error("gain decode wrong");
	property p_time_lo;
		slew_time_code_b2 == 4'h0 |=> slew_time_ns_b2 == 14'h015E;
	endproperty
	a_time_lo: assert property (p_time_lo) else $error("shortest time wrong");
	property p_time_hi;
		slew_time_code_b2 == 4'hF |=> slew_time_ns_b2 == 14'h3E58;
	endproperty
	a_time_hi: assert property (p_time_hi) else $error("longest time wrong");
	property p_miss;
		(reg_wr || reg_rd) && (reg_addr < 6'h35 || reg_addr > 6'h38) |=> reg_miss;
	endproperty
	a_miss: assert property (p_miss) else $error("unmapped access not flagged");
endmodule
bind slc_regs slc_props u_props (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.reg_miss(reg_miss), .slew_time_code_b2(slew_time_code_b2), .slew_loop_on_b2(slew_loop_on_b2),
	.slew_err_limit_b2(slew_err_limit_b2), .slew_gain_code_b2(slew_gain_code_b2),
	.slew_gain_b2(slew_gain_b2), .slew_time_ns_b2(slew_time_ns_b2),
	.slew_time_code_b3(slew_time_code_b3), .slew_time_code_b4(slew_time_code_b4));
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the slew-time loop bank.
// Assumes slc_regs, slc_pkg, the host model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        clk_sys = 1'b0;
	logic        rstn    = 1'b0;
	logic [5:0]  reg_addr;
	logic        reg_wr, reg_rd, reg_rvalid, reg_miss;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [3:0]  tc2;
	logic        on2, er2;
	logic [1:0]  gc2;
	logic [2:0]  g2;
	logic [13:0] ns2;
	logic [9:0]  r;
	wire  [7:0]  f1, f3, f4;
	wire  [2:0]  g1, g3, g4;
	wire  [13:0] n1, n3, n4;
	int          error_cnt = 0;
	int          checked   = 0;
	logic [13:0] ns_tab [16] = '{14'h015E, 14'h0230, 14'h0302, 14'h03D4, 14'h0532, 14'h0690, 14'h07EE,
		14'h0992, 14'h0B7C, 14'h0F96, 14'h136A, 14'h173E, 14'h1F2C, 14'h26D4, 14'h2EC2, 14'h3E58};
	always #20 clk_sys = ~clk_sys;
	slc_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_miss(reg_miss));
	slc_regs dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_miss(reg_miss),
		.slew_time_code_b1(f1[7:4]), .slew_loop_on_b1(f1[3]), .slew_err_limit_b1(f1[2]),
		.slew_gain_code_b1(f1[1:0]), .slew_gain_b1(g1), .slew_time_ns_b1(n1),
		.slew_time_code_b2(tc2), .slew_loop_on_b2(on2),
		.slew_err_limit_b2(er2), .slew_gain_code_b2(gc2), .slew_gain_b2(g2), .slew_time_ns_b2(ns2),
		.slew_time_code_b3(f3[7:4]), .slew_loop_on_b3(f3[3]), .slew_err_limit_b3(f3[2]),
		.slew_gain_code_b3(f3[1:0]), .slew_gain_b3(g3), .slew_time_ns_b3(n3),
		.slew_time_code_b4(f4[7:4]), .slew_loop_on_b4(f4[3]), .slew_err_limit_b4(f4[2]),
		.slew_gain_code_b4(f4[1:0]), .slew_gain_b4(g4), .slew_time_ns_b4(n4));
	////////////////////////////////
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic rc(input logic [5:0] a, input logic [9:0] e);
		host.rd(a, r);
		chk("read", {6'h00, r}, {6'h00, e});
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Whole run is near 80 cycles; the limit leaves ample margin
	initial begin
		#20000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		for (int i = 0; i < 4; i++) rc(6'h35 + 6'(i), 10'h123);
		chk("reset gain", 16'(g2), 16'h0004);
		chk("reset time", 16'(ns2), 16'(ns_tab[2]));
		chk("reset b1", 16'(f1), 16'h0023);
		$display("reset values done");
		for (int i = 0; i < 4; i++) host.wr(6'h35 + 6'(i), 8'h5C + 8'(i * 17));
		host.wr(6'h3F, 8'hFF);
		for (int i = 0; i < 4; i++) rc(6'h35 + 6'(i), {2'b01, 8'h5C + 8'(i * 17)});
		rc(6'h3F, 10'h300);
		$display("readback done");
		for (int i = 0; i < 16; i++) begin
			d = {4'(i), i[0], i[1], i[1:0]};
			host.wr(6'h36, d);
			@(negedge clk_sys);
			chk("fields", {8'h00, tc2, on2, er2, gc2}, {8'h00, d});
			chk("gain", 16'(g2), 16'({1'b0, d[1:0]} + 3'h1));
			chk("time", 16'(ns2), 16'(ns_tab[i]));
		end
		// Bridge 2 traffic must leave the other bridges as written
		chk("b1 fields", 16'(f1), 16'h005C);
		chk("b3 fields", 16'(f3), 16'h007E);
		chk("b4 fields", 16'(f4), 16'h008F);
		chk("b1 time", 16'(n1), 16'(ns_tab[5]));
		chk("b3 time", 16'(n3), 16'(ns_tab[7]));
		chk("b4 time", 16'(n4), 16'(ns_tab[8]));
		chk("b1 gain", 16'(g1), 16'h0001);
		chk("b3 gain", 16'(g3), 16'h0003);
		chk("b4 gain", 16'(g4), 16'h0004);
		$display("field decode done");
		rstn = 1'b0;
		@(negedge clk_sys);
		rstn = 1'b1;
		rc(6'h36, 10'h123);
		chk("reset b3", 16'(f3), 16'h0023);
		chk("reset b4 time", 16'(n4), 16'(ns_tab[2]));
		$display("mid-run reset done");
		conclude();
	end
endmodule
`default_nettype wire

// ---- hw/slc_cfg_reg.sv ----
// One byte of bridge configuration with its own address decode.
// Assumes writes are single-cycle strobes from the serial register port.
`timescale 1ns/1ns
`default_nettype none

module slc_cfg_reg #(
	parameter logic [slc_pkg::SLC_ADDR_W-1:0] ADDR    = slc_pkg::SLC_ADDR_CFG_B1,
	parameter logic [slc_pkg::SLC_DATA_W-1:0] RST_VAL = slc_pkg::SLC_RST_VAL
) (
	// Clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rstn,
	// Register port
	input  wire logic [slc_pkg::SLC_ADDR_W-1:0]    reg_addr,
	input  wire logic                              reg_wr,
	input  wire logic [slc_pkg::SLC_DATA_W-1:0]    reg_wdata,
	// Decode and contents
	output logic                                   hit,
	output logic      [slc_pkg::SLC_DATA_W-1:0]    value
);
	import slc_pkg::*;

	logic [SLC_DATA_W-1:0] next_value;

	assign hit        = (reg_addr == ADDR);
	// All bits plain read/write; nothing else is touched by a write
	assign next_value = (hit && reg_wr) ? reg_wdata : value;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			value <= RST_VAL;
		end else begin
			value <= next_value;
		end
	end

endmodule

`default_nettype wire

// ---- hw/slc_pkg.sv ----
// Constants for the slew-time loop configuration bank.
// Assumes a byte-wide serial register port with 6-bit addresses, clocked by clk_sys.
`default_nettype none

package slc_pkg;

	localparam int SLC_ADDR_W   = 6;
	localparam int SLC_DATA_W   = 8;
	localparam int SLC_TIME_W   = 14;
	localparam int SLC_BRIDGES  = 4;

	// Register offsets, bridge 1 to 4
	localparam logic [SLC_ADDR_W-1:0] SLC_ADDR_CFG_B1 = 6'h35;
	localparam logic [SLC_ADDR_W-1:0] SLC_ADDR_CFG_B2 = 6'h36;
	localparam logic [SLC_ADDR_W-1:0] SLC_ADDR_CFG_B3 = 6'h37;
	localparam logic [SLC_ADDR_W-1:0] SLC_ADDR_CFG_B4 = 6'h38;

	// Common reset value of every bridge register
	localparam logic [SLC_DATA_W-1:0] SLC_RST_VAL    = 8'h23;
	localparam logic [SLC_DATA_W-1:0] SLC_UNMAPPED   = 8'h00;

	// Field positions
	localparam int SLC_TIME_MSB  = 7;
	localparam int SLC_TIME_LSB  = 4;
	localparam int SLC_LOOP_BIT  = 3;
	localparam int SLC_ERR_BIT   = 2;
	localparam int SLC_GAIN_MSB  = 1;
	localparam int SLC_GAIN_LSB  = 0;

	// Target rise/fall time in ns, one entry per code
	localparam logic [SLC_TIME_W-1:0] SLC_TIME_NS [16] = '{
		14'h015E, 14'h0230, 14'h0302, 14'h03D4,
		14'h0532, 14'h0690, 14'h07EE, 14'h0992,
		14'h0B7C, 14'h0F96, 14'h136A, 14'h173E,
		14'h1F2C, 14'h26D4, 14'h2EC2, 14'h3E58
	};

	// Error limit modes
	typedef enum logic {
		SLC_ERR_ONE_BIT = 1'b0,
		SLC_ERR_ACTUAL  = 1'b1
	} slc_err_mode_t;

	function automatic logic [SLC_TIME_W-1:0] slc_time_ns(input logic [3:0] code);
		slc_time_ns = SLC_TIME_NS[code];
	endfunction

	function automatic logic [2:0] slc_gain_val(input logic [1:0] code);
		slc_gain_val = {1'b0, code} + 3'h1;
	endfunction

	localparam logic [SLC_TIME_W-1:0] SLC_RST_TIME_NS = slc_time_ns(SLC_RST_VAL[SLC_TIME_MSB:SLC_TIME_LSB]);
	localparam logic [2:0]            SLC_RST_GAIN    = slc_gain_val(SLC_RST_VAL[SLC_GAIN_MSB:SLC_GAIN_LSB]);

endpackage

`default_nettype wire

// ---- hw/slc_regs.sv ----
// Slew-time loop configuration bank for half-bridges 1 to 4.
// Assumes the serial front end hands over decoded byte accesses: one-cycle read and write
// strobes with address and data valid in the same cycle, all synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none

module slc_regs (
	// Clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rstn,
	// Register port
	input  wire logic [slc_pkg::SLC_ADDR_W-1:0]    reg_addr,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	input  wire logic [slc_pkg::SLC_DATA_W-1:0]    reg_wdata,
	output logic      [slc_pkg::SLC_DATA_W-1:0]    reg_rdata,
	output logic                                   reg_rvalid,
	output logic                                   reg_miss,
	// Half-bridge 1
	output logic      [3:0]                        slew_time_code_b1,
	output logic                                   slew_loop_on_b1,
	output logic                                   slew_err_limit_b1,
	output logic      [1:0]                        slew_gain_code_b1,
	output logic      [2:0]                        slew_gain_b1,
	output logic      [slc_pkg::SLC_TIME_W-1:0]    slew_time_ns_b1,
	// Half-bridge 2
	output logic      [3:0]                        slew_time_code_b2,
	output logic                                   slew_loop_on_b2,
	output logic                                   slew_err_limit_b2,
	output logic      [1:0]                        slew_gain_code_b2,
	output logic      [2:0]                        slew_gain_b2,
	output logic      [slc_pkg::SLC_TIME_W-1:0]    slew_time_ns_b2,
	// Half-bridge 3
	output logic      [3:0]                        slew_time_code_b3,
	output logic                                   slew_loop_on_b3,
	output logic                                   slew_err_limit_b3,
	output logic      [1:0]                        slew_gain_code_b3,
	output logic      [2:0]                        slew_gain_b3,
	output logic      [slc_pkg::SLC_TIME_W-1:0]    slew_time_ns_b3,
	// Half-bridge 4
	output logic      [3:0]                        slew_time_code_b4,
	output logic                                   slew_loop_on_b4,
	output logic                                   slew_err_limit_b4,
	output logic      [1:0]                        slew_gain_code_b4,
	output logic      [2:0]                        slew_gain_b4,
	output logic      [slc_pkg::SLC_TIME_W-1:0]    slew_time_ns_b4
);
	import slc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [SLC_BRIDGES-1:0] br_hit;
	logic [SLC_DATA_W-1:0]  br_val [SLC_BRIDGES];

	// Every bridge resets to the same value; one instance per bridge keeps
	// each decoded address in plain sight
	// Half-bridge 1 at 35h
	slc_cfg_reg #(
		.ADDR    (SLC_ADDR_CFG_B1),
		.RST_VAL (SLC_RST_VAL)
	) u_reg_b1 (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.hit       (br_hit[0]),
		.value     (br_val[0])
	);

	// Half-bridge 2 at 36h
	slc_cfg_reg #(
		.ADDR    (SLC_ADDR_CFG_B2),
		.RST_VAL (SLC_RST_VAL)
	) u_reg_b2 (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.hit       (br_hit[1]),
		.value     (br_val[1])
	);

	// Half-bridge 3 at 37h
	slc_cfg_reg #(
		.ADDR    (SLC_ADDR_CFG_B3),
		.RST_VAL (SLC_RST_VAL)
	) u_reg_b3 (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.hit       (br_hit[2]),
		.value     (br_val[2])
	);

	// Half-bridge 4 at 38h
	slc_cfg_reg #(
		.ADDR    (SLC_ADDR_CFG_B4),
		.RST_VAL (SLC_RST_VAL)
	) u_reg_b4 (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_wdata (reg_wdata),
		.hit       (br_hit[3]),
		.value     (br_val[3])
	);

	genvar gi;

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	wire                  any_hit;
	wire                  acc_miss;
	wire [SLC_DATA_W-1:0] rd_sel;
	logic [SLC_DATA_W-1:0] next_rdata;

	assign any_hit = |br_hit;
	// Unmapped writes are dropped silently, so the flag is the host's only hint
	assign acc_miss = (reg_rd || reg_wr) && !any_hit;

	// Hits are one-hot, so an OR of gated values is a plain select
	assign rd_sel = ({SLC_DATA_W{br_hit[0]}} & br_val[0])
	              | ({SLC_DATA_W{br_hit[1]}} & br_val[1])
	              | ({SLC_DATA_W{br_hit[2]}} & br_val[2])
	              | ({SLC_DATA_W{br_hit[3]}} & br_val[3]);

	// Reads return the stored byte, or SLC_UNMAPPED when no bridge hits, and leave it untouched
	assign next_rdata = reg_rd ? (any_hit ? rd_sel : SLC_UNMAPPED) : reg_rdata;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata  <= SLC_UNMAPPED;
			reg_rvalid <= 1'b0;
			reg_miss   <= 1'b0;
		end else begin
			reg_rdata  <= next_rdata;
			reg_rvalid <= reg_rd;
			reg_miss   <= acc_miss;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field decode
	// Raw fields come straight from the register flops; the looked-up time and gain
	// are registered once more, so they follow a write one cycle later.

	wire [3:0]            f_time [SLC_BRIDGES];
	wire                  f_loop [SLC_BRIDGES];
	wire                  f_err  [SLC_BRIDGES];
	wire [1:0]            f_gain [SLC_BRIDGES];
	logic [SLC_TIME_W-1:0] t_ns  [SLC_BRIDGES];
	logic [2:0]            g_val [SLC_BRIDGES];
	wire [SLC_TIME_W-1:0]  next_t_ns  [SLC_BRIDGES];
	wire [2:0]             next_g_val [SLC_BRIDGES];

	generate
		for (gi = 0; gi < SLC_BRIDGES; gi++) begin : g_dec
			assign f_time[gi] = br_val[gi][SLC_TIME_MSB:SLC_TIME_LSB];
			assign f_loop[gi] = br_val[gi][SLC_LOOP_BIT];
			assign f_err[gi]  = br_val[gi][SLC_ERR_BIT];
			assign f_gain[gi] = br_val[gi][SLC_GAIN_MSB:SLC_GAIN_LSB];
			assign next_t_ns[gi]  = slc_time_ns(f_time[gi]);
			assign next_g_val[gi] = slc_gain_val(f_gain[gi]);

			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					t_ns[gi]  <= SLC_RST_TIME_NS;
					g_val[gi] <= SLC_RST_GAIN;
				end else begin
					t_ns[gi]  <= next_t_ns[gi];
					g_val[gi] <= next_g_val[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Per-bridge outputs

	// Half-bridge 1 shares the layout; its loop sits beside this bank
	assign slew_time_code_b1 = f_time[0];
	assign slew_loop_on_b1   = f_loop[0];
	assign slew_err_limit_b1 = f_err[0];
	assign slew_gain_code_b1 = f_gain[0];
	assign slew_gain_b1      = g_val[0];
	assign slew_time_ns_b1   = t_ns[0];

	// Half-bridge 2
	assign slew_time_code_b2 = f_time[1];
	assign slew_loop_on_b2   = f_loop[1];
	assign slew_err_limit_b2 = f_err[1];
	assign slew_gain_code_b2 = f_gain[1];
	assign slew_gain_b2      = g_val[1];
	assign slew_time_ns_b2   = t_ns[1];

	// Half-bridge 3
	assign slew_time_code_b3 = f_time[2];
	assign slew_loop_on_b3   = f_loop[2];
	assign slew_err_limit_b3 = f_err[2];
	assign slew_gain_code_b3 = f_gain[2];
	assign slew_gain_b3      = g_val[2];
	assign slew_time_ns_b3   = t_ns[2];

	// Half-bridge 4
	assign slew_time_code_b4 = f_time[3];
	assign slew_loop_on_b4   = f_loop[3];
	assign slew_err_limit_b4 = f_err[3];
	assign slew_gain_code_b4 = f_gain[3];
	assign slew_gain_b4      = g_val[3];
	assign slew_time_ns_b4   = t_ns[3];

endmodule

`default_nettype wire
